/* File: verilog/mpt_timer.sv */
// Purpose: match based pwm timer with axi4-lite registers
// Assumes: capture inputs asynchronous, synchronised here
// Notes:   all state held in one struct register
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module mpt_timer (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// register bus
	input  wire mpt_pkg::mpt_axi_req_s axi_req,
	output      mpt_pkg::mpt_axi_rsp_s axi_rsp,
	// pins
	input  wire logic [1:0]            cap_in,
	output      logic [5:0]            pwm_out
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic is_match(input logic [7:0] a);
		return (a >= mpt_pkg::OFF_MATCH0) && (a < mpt_pkg::OFF_MATCH0 + 8'h1C);
	endfunction

	function automatic logic [2:0] match_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - mpt_pkg::OFF_MATCH0;
		return d[4:2];
	endfunction

	function automatic logic [32:0] rd_word(input mpt_pkg::mpt_state_s st,
		input logic [7:0] addr);
		logic [7:0] a;
		a = {addr[7:2], 2'b00};
		if (is_match(a)) begin
			return {1'b1, st.shadow[match_idx(a)]};
		end
		case (a)
			mpt_pkg::OFF_CTRL:     return {1'b1, 26'h0, st.ctrl};
			mpt_pkg::OFF_PRESCALE: return {1'b1, st.prescale};
			mpt_pkg::OFF_PSCOUNT:  return {1'b1, st.pc};
			mpt_pkg::OFF_COUNT:    return {1'b1, st.tc};
			mpt_pkg::OFF_MCTRL:    return {1'b1, 11'h0, st.mctrl};
			mpt_pkg::OFF_PWMCTRL:  return {1'b1, 18'h0, st.out_ena, 2'b00, st.dbl_sel, 1'b0};
			mpt_pkg::OFF_RELEASE:  return {1'b1, 25'h0, st.release_bits};
			mpt_pkg::OFF_FLAGS:    return {1'b1, 23'h0, st.flags};
			mpt_pkg::OFF_CAP0:     return {1'b1, st.cap[0]};
			mpt_pkg::OFF_CAP1:     return {1'b1, st.cap[1]};
			mpt_pkg::OFF_CAPCTRL:  return {1'b1, 26'h0, st.capctrl};
			default:               return 33'h0_0000_0000;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// state and next state
	// ---------------------------------------------------------------
	mpt_pkg::mpt_state_s s;
	mpt_pkg::mpt_state_s next_s;
	logic [6:0]          hit;
	logic                tick;
	logic                inc;
	logic                run;
	logic                pwm_en;
	logic [1:0]          rise;
	logic [1:0]          fall;
	logic [1:0]          cap_ev;
	logic [8:0]          flag_set;
	logic [32:0]         rd;
	logic [32:0]         rq;
	logic [31:0]         wv;

	// bus handshakes from held state
	assign axi_rsp.awready = !s.aw_held && !s.bvalid;
	assign axi_rsp.wready  = !s.w_held && !s.bvalid;
	assign axi_rsp.bvalid  = s.bvalid;
	assign axi_rsp.bresp   = s.bresp;
	assign axi_rsp.arready = !s.rvalid;
	assign axi_rsp.rvalid  = s.rvalid;
	assign axi_rsp.rdata   = s.rdata;
	assign axi_rsp.rresp   = s.rresp;
	assign pwm_out         = s.pwm_out;

	// next state: timer, outputs, bus
	always_comb begin
		next_s   = s;
		flag_set = '0;
		rd       = 33'h0_0000_0000;
		rq       = 33'h0_0000_0000;
		wv       = 32'h0000_0000;
		pwm_en   = s.ctrl[mpt_pkg::CTRL_PWM];
		run      = s.ctrl[mpt_pkg::CTRL_EN] && !s.ctrl[mpt_pkg::CTRL_CLR];
		// capture synchronisers
		next_s.sync1 = cap_in;
		next_s.sync2 = s.sync1;
		next_s.sync3 = s.sync2;
		rise = s.sync2 & ~s.sync3;
		fall = ~s.sync2 & s.sync3;
		// count source: clock or capture edge
		if (s.ctrl[mpt_pkg::CTRL_MODE +: 2] == 2'b00) begin
			inc = 1'b1;
		end else begin
			inc = (s.ctrl[mpt_pkg::CTRL_MODE] && rise[s.ctrl[mpt_pkg::CTRL_INSEL]])
				|| (s.ctrl[mpt_pkg::CTRL_MODE + 1] && fall[s.ctrl[mpt_pkg::CTRL_INSEL]]);
		end
		tick = run && inc && (s.pc == s.prescale);
		// match compare on every count value
		for (int i = 0; i < mpt_pkg::NUM_MATCH; i++) begin
			hit[i] = tick && (s.tc == s.active[i]);
		end
		// prescaler and counter
		if (s.ctrl[mpt_pkg::CTRL_CLR]) begin
			next_s.pc = 32'h0000_0000;
			next_s.tc = 32'h0000_0000;
		end else if (run && inc) begin
			next_s.pc = tick ? 32'h0000_0000 : s.pc + 32'h0000_0001;
		end
		if (tick) begin
			next_s.tc = s.tc + 32'h0000_0001;
		end
		// match actions
		for (int i = 0; i < mpt_pkg::NUM_MATCH; i++) begin
			if (hit[i] && (s.mctrl[3*i+1] || (i == 0 && pwm_en))) begin
				next_s.tc = 32'h0000_0000;
			end
			if (hit[i] && s.mctrl[3*i+2]) begin
				next_s.ctrl[mpt_pkg::CTRL_EN] = 1'b0;
			end
			flag_set[i] = hit[i] && s.mctrl[3*i];
		end
		// match value transfer from shadow
		for (int i = 0; i < mpt_pkg::NUM_MATCH; i++) begin
			if (!pwm_en) begin
				next_s.active[i] = s.shadow[i];
			end else if (hit[0] && s.release_bits[i]) begin
				next_s.active[i]       = s.shadow[i];
				next_s.release_bits[i] = 1'b0;
			end
		end
		// pwm outputs
		for (int k = 0; k < mpt_pkg::NUM_OUT; k++) begin
			logic dbl;
			logic set_e;
			logic clr_e;
			dbl   = (k > 0) && s.dbl_sel[(k > 0) ? k - 1 : 0];
			set_e = dbl ? hit[k] : hit[0];
			clr_e = hit[k+1];
			if (!pwm_en || !s.out_ena[k]) begin
				next_s.pwm_out[k] = 1'b0;
			end else if (clr_e) begin
				next_s.pwm_out[k] = 1'b0;
			end else if (set_e) begin
				next_s.pwm_out[k] = 1'b1;
			end
		end
		// capture events
		for (int c = 0; c < 2; c++) begin
			cap_ev[c] = (s.capctrl[3*c] && rise[c]) || (s.capctrl[3*c+1] && fall[c]);
			if (cap_ev[c]) begin
				next_s.cap[c] = s.tc;
			end
			flag_set[mpt_pkg::FLAG_CAP + c] = cap_ev[c] && s.capctrl[3*c+2];
		end
		// bus write channels
		if (axi_req.awvalid && axi_rsp.awready) begin
			next_s.aw_held = 1'b1;
			next_s.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && axi_rsp.wready) begin
			next_s.w_held = 1'b1;
			next_s.w_data = axi_req.wdata;
			next_s.w_strb = axi_req.wstrb;
		end
		if (s.bvalid && axi_req.bready) begin
			next_s.bvalid = 1'b0;
		end
		// register write once address and data are both held
		if (s.aw_held && s.w_held && !s.bvalid) begin
			rd             = rd_word(s, s.aw_addr);
			wv             = merge_strb(rd[31:0], s.w_data, s.w_strb);
			next_s.aw_held = 1'b0;
			next_s.w_held  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = rd[32] ? mpt_pkg::RESP_OKAY : mpt_pkg::RESP_SLV;
			if (is_match({s.aw_addr[7:2], 2'b00})) begin
				next_s.shadow[match_idx({s.aw_addr[7:2], 2'b00})] = wv;
			end
			case ({s.aw_addr[7:2], 2'b00})
				mpt_pkg::OFF_CTRL:     next_s.ctrl     = wv[5:0];
				mpt_pkg::OFF_PRESCALE: next_s.prescale = wv;
				mpt_pkg::OFF_COUNT:    next_s.tc       = wv;
				mpt_pkg::OFF_MCTRL:    next_s.mctrl    = wv[20:0];
				mpt_pkg::OFF_PWMCTRL: begin
					next_s.dbl_sel = wv[5:1];
					next_s.out_ena = wv[mpt_pkg::PWM_ENA +: 6];
				end
				mpt_pkg::OFF_RELEASE: begin
					next_s.release_bits = next_s.release_bits | (s.w_data[6:0]
						& {7{s.w_strb[0]}});
				end
				mpt_pkg::OFF_FLAGS: begin
					next_s.flags = s.flags & ~(s.w_data[8:0]
						& {{1{s.w_strb[1]}}, {8{s.w_strb[0]}}});
				end
				mpt_pkg::OFF_CAPCTRL:  next_s.capctrl  = wv[5:0];
				default: begin
				end
			endcase
		end
		// hardware set wins over software clear
		next_s.flags = next_s.flags | flag_set;
		// read channel
		if (s.rvalid && axi_req.rready) begin
			next_s.rvalid = 1'b0;
		end
		// bit 32 of the looked-up word marks a mapped address
		if (axi_req.arvalid && axi_rsp.arready) begin
			rq            = rd_word(s, axi_req.araddr);
			next_s.rvalid = 1'b1;
			next_s.rdata  = rq[31:0];
			next_s.rresp  = rq[32] ? mpt_pkg::RESP_OKAY : mpt_pkg::RESP_SLV;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= mpt_pkg::ST_RST;
		end else begin
			s <= next_s;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// pwm period and output edges
	a_period_clear: assert property (hit[0] && pwm_en && !s.ctrl[mpt_pkg::CTRL_CLR]
		&& !(s.aw_held && s.w_held) |=> s.tc == 32'h0000_0000)
		else $error("cycle match did not clear counter");
	a_single_fall: assert property (hit[1] && pwm_en && s.out_ena[0] |=> !pwm_out[0])
		else $error("single edge output missed its falling match");
	a_start_high: assert property (hit[0] && !hit[1] && pwm_en && s.out_ena[0]
		|=> pwm_out[0])
		else $error("single edge output not high at period start");
	a_double_rise: assert property (hit[2] && !hit[3] && pwm_en && s.out_ena[2]
		&& s.dbl_sel[1] |=> pwm_out[2])
		else $error("double edge output missed rising match");
	a_double_fall: assert property (hit[3] && pwm_en && s.out_ena[2] && s.dbl_sel[1]
		|=> !pwm_out[2])
		else $error("double edge output missed falling match");
	a_off_low: assert property (!pwm_en |=> pwm_out == 6'h00)
		else $error("output active with pwm off");
	// match values and match actions
	a_hold_unreleased: assert property (pwm_en && $stable(pwm_en) && !hit[0]
		|=> $stable(s.active))
		else $error("match value changed outside period boundary");
	a_release_apply: assert property (hit[0] && pwm_en && s.release_bits[1]
		|=> s.active[1] == $past(s.shadow[1]))
		else $error("released match value not applied at period start");
	a_stop_match: assert property (hit[1] && s.mctrl[5] && !(s.aw_held && s.w_held)
		|=> !s.ctrl[mpt_pkg::CTRL_EN])
		else $error("stop on match did not halt timer");
	// counting, capture, flags and write response
	a_capture_copy: assert property (cap_ev[0] |=> s.cap[0] == $past(s.tc))
		else $error("capture register did not take counter");
	a_cap_flag: assert property (cap_ev[1] && s.capctrl[5] |=> s.flags[8])
		else $error("capture event did not raise its flag");
	a_presc_wrap: assert property (tick && !s.ctrl[mpt_pkg::CTRL_CLR]
		|=> s.pc == 32'h0000_0000)
		else $error("prescaler did not restart");
	a_count_hold: assert property (!s.ctrl[mpt_pkg::CTRL_EN]
		&& !s.ctrl[mpt_pkg::CTRL_CLR] && !(s.aw_held && s.w_held)
		|=> $stable(s.tc))
		else $error("stopped counter moved");
	a_edge_only: assert property (run && s.ctrl[mpt_pkg::CTRL_MODE +: 2] == 2'b01
		&& !rise[s.ctrl[mpt_pkg::CTRL_INSEL]] && !(s.aw_held && s.w_held)
		|=> $stable(s.tc))
		else $error("counter moved without a counting edge");
	a_flag_sticky: assert property (s.flags[1] && !(s.aw_held && s.w_held)
		|=> s.flags[1])
		else $error("flag dropped without clear");
	a_bus_hold: assert property (s.bvalid && !axi_req.bready |=> s.bvalid)
		else $error("write response dropped early");

	// main scenarios reached
	c_period: cover property (hit[0] && pwm_en ##[1:200] hit[0]);
	c_double: cover property (hit[2] && s.dbl_sel[1] && s.out_ena[2]);
	c_capture: cover property (cap_ev[1]);
	c_release: cover property (hit[0] && pwm_en && s.release_bits[2]);

endmodule

/* File: pkg/mpt_pkg.sv */
// Purpose: constants and types of the match based pwm timer
// Assumes: axi4-lite register access, 32-bit data, one clock
// Notes:   byte offsets, word aligned
//
// What this block does
// - a cycle match clears the counter and sets the shared period
// - single-edge output uses cycle match plus one match for its edge
// - extra single-edge output costs one match, double-edge costs two
// - single-edge outputs go high at cycle match unless held low
// - double-edge output uses cycle match plus rising and falling matches
// - rising first gives positive pulse, falling first gives negative pulse
// - both double edges may sit anywhere in the period, any order
// - seven match registers serve six single or three double outputs
// - per match: continue, stop or reset, each with optional flag
// - period and width take any whole count value
// - in pwm mode new match values apply only at period start after release
// - timer counts clock cycles, counter counts capture input edges
// - with pwm off it is a plain 32-bit timer with prescaler
// - capture edge copies counter into capture register, optional flag
package mpt_pkg;

	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_PRESCALE = 8'h04;
	localparam logic [7:0] OFF_PSCOUNT  = 8'h08;
	localparam logic [7:0] OFF_COUNT    = 8'h0C;
	localparam logic [7:0] OFF_MCTRL    = 8'h10;
	localparam logic [7:0] OFF_PWMCTRL  = 8'h14;
	localparam logic [7:0] OFF_RELEASE  = 8'h18;
	localparam logic [7:0] OFF_FLAGS    = 8'h1C;
	localparam logic [7:0] OFF_CAP0     = 8'h20;
	localparam logic [7:0] OFF_CAP1     = 8'h24;
	localparam logic [7:0] OFF_CAPCTRL  = 8'h28;
	localparam logic [7:0] OFF_MATCH0   = 8'h40;

	// ---------------------------------------------------------------
	// field positions and codes
	// ---------------------------------------------------------------
	localparam int          NUM_MATCH  = 7;
	localparam int          NUM_OUT    = 6;
	localparam int          CTRL_EN    = 0;
	localparam int          CTRL_CLR   = 1;
	localparam int          CTRL_PWM   = 2;
	localparam int          CTRL_MODE  = 3;
	localparam int          CTRL_INSEL = 5;
	localparam int          PWM_ENA    = 8;
	localparam int          FLAG_CAP   = 7;
	localparam logic [1:0]  RESP_OKAY  = 2'b00;
	localparam logic [1:0]  RESP_SLV   = 2'b10;

	// ---------------------------------------------------------------
	// bus carriers and block state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} mpt_axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} mpt_axi_rsp_s;

	typedef struct packed {
		logic             aw_held;
		logic [7:0]       aw_addr;
		logic             w_held;
		logic [31:0]      w_data;
		logic [3:0]       w_strb;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [1:0]       rresp;
		logic [31:0]      rdata;
		logic [5:0]       ctrl;
		logic [31:0]      prescale;
		logic [31:0]      pc;
		logic [31:0]      tc;
		logic [20:0]      mctrl;
		logic [4:0]       dbl_sel;
		logic [5:0]       out_ena;
		logic [6:0]       release_bits;
		logic [8:0]       flags;
		logic [1:0][31:0] cap;
		logic [5:0]       capctrl;
		logic [6:0][31:0] shadow;
		logic [6:0][31:0] active;
		logic [5:0]       pwm_out;
		logic [1:0]       sync1;
		logic [1:0]       sync2;
		logic [1:0]       sync3;
	} mpt_state_s;

	localparam mpt_state_s ST_RST = '0;

endpackage

/* File: testbench/mpt_load_model.sv */
// Purpose: load monitor on the pwm pins, source of capture pulses
// Assumes: pwm_out sampled on rising clk
// Notes:   widths and periods counted in clk cycles
`timescale 1ns/1ps
module mpt_load_model (
	// clock
	input  wire logic       clk,
	// pins
	input  wire logic [5:0] pwm_out,
	output      logic [1:0] cap_in
);
	int         hi_cnt [6];
	int         per_cnt[6];
	int         hi_len [6];
	int         per_len[6];
	logic [5:0] prv = '0;

	// high time and rise to rise spacing per output
	always @(posedge clk) begin
		for (int k = 0; k < 6; k++) begin
			if (pwm_out[k] && !prv[k]) begin
				per_len[k] = per_cnt[k];
				per_cnt[k] = 1;
				hi_cnt[k] = 1;
			end else begin
				per_cnt[k]++;
				if (pwm_out[k]) hi_cnt[k]++;
				if (!pwm_out[k] && prv[k]) hi_len[k] = hi_cnt[k];
			end
		end
		prv = pwm_out;
	end

	// capture pins idle low, one slow clean pulse on request
	initial cap_in = '0;
	task automatic pulse(input int c);
		repeat (4) @(posedge clk);
		cap_in[c] <= 1'b1;
		repeat (4) @(posedge clk);
		cap_in[c] <= 1'b0;
	endtask
endmodule

/* File: testbench/tb.sv */
// Purpose: self-checking bench of the match based pwm timer
// Assumes: axi4-lite master driven after rising edges
// Notes:   pwm widths predicted from integer model, random from lfsr
`timescale 1ns/1ps
module tb;
	logic                  clk;
	logic                  rst_n;
	mpt_pkg::mpt_axi_req_s req;
	mpt_pkg::mpt_axi_rsp_s rsp;
	logic [1:0]            cap_in;
	logic [5:0]            pwm_out;
	int                    fail_count;
	int                    n_checks;
	logic [15:0]           lfsr = 16'h0025;
	logic [1:0]            resp;
	logic [31:0]           rd;
	int                    m[4];
	int                    o[4];
	int                    ps;
	int                    ops;

	mpt_timer u_dut (.clk(clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp),
		.cap_in(cap_in), .pwm_out(pwm_out));
	mpt_load_model u_load (.clk(clk), .pwm_out(pwm_out), .cap_in(cap_in));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// checks, bus tasks, model
	// ---------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask

	// write: address and data offered together, bready held until answer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) break;
		end
		resp = rsp.bresp;
		req.bready <= 1'b0;
		if (n == 50) begin
			fail_count++;
			summarize();
		end
		@(posedge clk);
	endtask

	// read: rready held until rvalid seen
	task automatic rdr(input logic [7:0] a);
		int n;
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid) break;
		end
		rd = rsp.rdata;
		resp = rsp.rresp;
		req.rready <= 1'b0;
		if (n == 50) begin
			fail_count++;
			summarize();
		end
		@(posedge clk);
	endtask

	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		rdr(a);
		chk(nm, e, rd);
	endtask

	function automatic int rnd(input int mx);
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return int'(lfsr) % mx;
	endfunction

	// expected high time: counts from rise tick to fall tick, wrapped
	function automatic int hi(input int r, input int f, input int p);
		return (f - r + p + 1) % (p + 1);
	endfunction

	task automatic chkpwm(input int v[4], input int s);
		// old period may still finish first; longest period is 52 counts
		repeat (4 * 52 * s + 8) @(posedge clk);
		chk("period", 32'(s * (v[0] + 1)), 32'(u_load.per_len[0]));
		chk("single high", 32'(s * (v[1] + 1)), 32'(u_load.hi_len[0]));
		chk("double high", 32'(s * hi(v[2], v[3], v[0])), 32'(u_load.hi_len[2]));
		chk("idle outs", 32'h0, 32'({pwm_out[5:3], pwm_out[1]}));
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		req = '0;
		rst_n = 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 7; i++) wr(mpt_pkg::OFF_MATCH0 + 8'(4 * i), 32'h0000_0100 + i);
		for (int i = 0; i < 7; i++) rc("match", mpt_pkg::OFF_MATCH0 + 8'(4 * i), 32'h0000_0100 + i);
		rdr(8'h30);
		chk("rresp", 32'(mpt_pkg::RESP_SLV), 32'(resp));
		chk("rdata", 32'h0, rd);
		wr(8'hfc, 32'h0000_0001);
		chk("bresp", 32'(mpt_pkg::RESP_SLV), 32'(resp));
		$display("test registers done");
		// continuous flag on match1, reset on match2
		wr(mpt_pkg::OFF_MATCH0 + 8'h04, 32'h0000_0002);
		wr(mpt_pkg::OFF_MATCH0 + 8'h08, 32'h0000_0003);
		wr(mpt_pkg::OFF_MCTRL, 32'h0000_0088);
		wr(mpt_pkg::OFF_CTRL, 32'h0000_0001);
		repeat (4) begin
			rdr(mpt_pkg::OFF_COUNT);
			chk("count bound", 32'h1, 32'(rd <= 3));
		end
		rc("flags", mpt_pkg::OFF_FLAGS, 32'h0000_0002);
		// stop on match1
		wr(mpt_pkg::OFF_CTRL, 32'h0000_0000);
		wr(mpt_pkg::OFF_FLAGS, 32'h0000_01ff);
		wr(mpt_pkg::OFF_COUNT, 32'h0000_0000);
		wr(mpt_pkg::OFF_MATCH0 + 8'h04, 32'h0000_0005);
		wr(mpt_pkg::OFF_MCTRL, 32'h0000_0028);
		wr(mpt_pkg::OFF_CTRL, 32'h0000_0001);
		repeat (40) @(posedge clk);
		// the stopping tick still advances the count one past the match
		rc("stopped count", mpt_pkg::OFF_COUNT, 32'h0000_0006);
		rc("stop flag", mpt_pkg::OFF_FLAGS, 32'h0000_0002);
		wr(mpt_pkg::OFF_FLAGS, 32'h0000_0002);
		rc("flag cleared", mpt_pkg::OFF_FLAGS, 32'h0000_0000);
		$display("test match actions done");
		// capture on rising edge of input 0 with flag
		wr(mpt_pkg::OFF_CAPCTRL, 32'h0000_0005);
		u_load.pulse(0);
		repeat (8) @(posedge clk);
		rc("capture", mpt_pkg::OFF_CAP0, 32'h0000_0006);
		rc("capture flag", mpt_pkg::OFF_FLAGS, 32'h0000_0080);
		wr(mpt_pkg::OFF_CAP0, 32'h0000_1234);
		rc("capture ro", mpt_pkg::OFF_CAP0, 32'h0000_0006);
		// counter mode on rising edges of input 0
		wr(mpt_pkg::OFF_CTRL, 32'h0000_0000);
		wr(mpt_pkg::OFF_MCTRL, 32'h0000_0000);
		wr(mpt_pkg::OFF_COUNT, 32'h0000_0000);
		wr(mpt_pkg::OFF_CTRL, 32'h0000_0009);
		repeat (3) u_load.pulse(0);
		repeat (8) @(posedge clk);
		rc("edge count", mpt_pkg::OFF_COUNT, 32'h0000_0003);
		// counter on falling edges of input 1, capture 1 on falling edge
		wr(mpt_pkg::OFF_CTRL, 32'h0000_0000);
		wr(mpt_pkg::OFF_COUNT, 32'h0000_0000);
		wr(mpt_pkg::OFF_CAPCTRL, 32'h0000_0030);
		wr(mpt_pkg::OFF_CTRL, 32'h0000_0031);
		repeat (3) u_load.pulse(1);
		repeat (8) @(posedge clk);
		rc("fall count", mpt_pkg::OFF_COUNT, 32'h0000_0003);
		rc("capture fall", mpt_pkg::OFF_CAP1, 32'h0000_0002);
		rc("capture flags", mpt_pkg::OFF_FLAGS, 32'h0000_0180);
		$display("test capture and counter done");
		// pwm: output 0 single edge, output 2 double edge
		wr(mpt_pkg::OFF_CTRL, 32'h0000_0000);
		wr(mpt_pkg::OFF_COUNT, 32'h0000_0000);
		wr(mpt_pkg::OFF_PWMCTRL, 32'h0000_0504);
		ops = 1;
		for (int r = 0; r < 3; r++) begin
			o = m;
			m[0] = 20 + rnd(32);
			m[1] = rnd(m[0]);
			m[2] = 1 + rnd(m[0] - 1);
			do m[3] = 1 + rnd(m[0] - 1); while (m[3] == m[2]);
			if ((r == 1) != (m[2] > m[3])) {m[2], m[3]} = {m[3], m[2]};
			for (int i = 0; i < 4; i++) wr(mpt_pkg::OFF_MATCH0 + 8'(4 * i), 32'(m[i]));
			if (r > 0) chkpwm(o, ops);
			ps = (r == 2) ? 2 : 1;
			wr(mpt_pkg::OFF_PRESCALE, 32'(ps - 1));
			wr(mpt_pkg::OFF_RELEASE, 32'h0000_000f);
			if (r == 0) wr(mpt_pkg::OFF_CTRL, 32'h0000_0005);
			chkpwm(m, ps);
			ops = ps;
			$display("test pwm round %0d done", r);
		end
		summarize();
	end
endmodule
